// *** logic/acio_dac.sv ***
// double-buffered converter channel code registers
`timescale 1ns/1ns
`default_nettype none
`include "acio_params.svh"
module acio_dac
  import acio_pkg::*;
(
  input  wire logic                              i_clk_sys,
  input  wire logic                              i_nrst,
  input  wire logic                              i_wr,
  input  wire logic [`ACIO_CH_W-1:0]             i_ch,
  input  wire logic [`ACIO_CODE_W-1:0]           i_code,
  output logic      [`ACIO_NCH*`ACIO_CODE_W-1:0] o_code,
  output logic      [`ACIO_NCH-1:0]              o_load
);

  acio_dac_state_t s_q;
  acio_dac_state_t s_d;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    for (int n = 0; n < `ACIO_NCH; n++) begin
      // second stage only ever copies a whole first-stage word
      if (s_q.pend_q[n]) begin
        s_d.stage2_q[n] = s_q.stage1_q[n];
      end
      s_d.pend_q[n] = 1'b0;
    end
    if (i_wr) begin
      s_d.stage1_q[i_ch] = i_code;
      s_d.pend_q[i_ch]   = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // one code feeds both the voltage and the current stage
  assign o_code = s_q.stage2_q;
  assign o_load = s_q.pend_q;
endmodule : acio_dac
`default_nettype wire

// *** logic/acio_irq.sv ***
// interrupt polarity select and live level status
`timescale 1ns/1ns
`default_nettype none
`include "acio_params.svh"
module acio_irq
  import acio_pkg::*;
(
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_nrst,
  input  wire logic [`ACIO_IRQ_N-1:0] i_irq_source,
  input  wire logic                   i_pol_wr,
  input  wire logic [`ACIO_IRQ_N-1:0] i_pol_wdata,
  output logic      [`ACIO_IRQ_N-1:0] o_irq_line,
  output logic      [`ACIO_IRQ_N-1:0] o_status
);

  acio_irq_state_t s_q;
  acio_irq_state_t s_d;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (i_pol_wr) begin
      s_d.pol_q = i_pol_wdata;
    end
    // bit one passes source, bit zero inverts it; per channel
    s_d.line_q = i_irq_source ^ ~s_d.pol_q;
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q.pol_q  <= `ACIO_POL_RST;
      s_q.line_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_irq_line = s_q.line_q;
  // live level, never latched, so a re-read shows the present state
  assign o_status   = s_q.line_q;
endmodule : acio_irq
`default_nettype wire

// *** logic/acio_params.svh ***
// constants for the analog card digital i/o logic
`ifndef ACIO_PARAMS_SVH
`define ACIO_PARAMS_SVH

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define ACIO_IO_W        8
`define ACIO_ADDR_W      8
`define ACIO_DIO_W       16
`define ACIO_CODE_W      14
`define ACIO_NCH         16
`define ACIO_CH_W        4
`define ACIO_IRQ_N       2

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define ACIO_OFS_IRQ_STATUS  8'h07
`define ACIO_OFS_IRQ_POL     8'h2a
`define ACIO_OFS_DI_LO       8'hc0
`define ACIO_OFS_DI_HI       8'hc1
`define ACIO_OFS_DO_LO       8'hc2
`define ACIO_OFS_DO_HI       8'hc3
`define ACIO_OFS_DA_LO       8'he0
`define ACIO_OFS_DA_HI       8'he1
`define ACIO_OFS_DA_CH       8'he2
`define ACIO_OFS_CAL_SEL     8'he4
`define ACIO_OFS_CAL_LO      8'he5
`define ACIO_OFS_CAL_HI      8'he6

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define ACIO_DA_HI_MSB       5
`define ACIO_CAL_CH_LSB      0
`define ACIO_CAL_KIND_LSB    4
`define ACIO_POL_RST         2'h0
`define ACIO_CODE_MIN        14'h0000
`define ACIO_CODE_MAX        14'h3fff
`define ACIO_CAL_ZERO_DEF    14'h2000

`endif

// *** logic/acio_pkg.sv ***
// types shared by the analog card digital i/o logic
`include "acio_params.svh"
package acio_pkg;

  typedef enum logic [1:0] {
    CAL_VOLT_LOW,
    CAL_VOLT_HIGH,
    CAL_CURR_ZERO,
    CAL_CURR_FULL
  } acio_cal_kind_t;

  typedef logic [`ACIO_CODE_W-1:0] acio_code_t;

  typedef struct packed {
    logic [`ACIO_IRQ_N-1:0] pol_q;
    logic [`ACIO_IRQ_N-1:0] line_q;
  } acio_irq_state_t;

  typedef struct packed {
    acio_code_t [`ACIO_NCH-1:0] stage1_q;
    acio_code_t [`ACIO_NCH-1:0] stage2_q;
    logic [`ACIO_NCH-1:0]       pend_q;
  } acio_dac_state_t;

  typedef struct packed {
    logic [`ACIO_DIO_W-1:0] di_q;
    logic                   di_en_q;
    logic [`ACIO_DIO_W-1:0] do_q;
    logic [`ACIO_IO_W-1:0]  rdata_q;
    logic [`ACIO_IO_W-1:0]  lo_byte_q;
    logic [`ACIO_CH_W-1:0]  ch_q;
    logic [`ACIO_CH_W-1:0]  cal_ch_q;
    acio_cal_kind_t         cal_kind_q;
  } acio_top_state_t;

endpackage : acio_pkg

// *** logic/acio_top.sv ***
// analog card digital logic: host i/o registers, dio, dac codes, irq
`timescale 1ns/1ns
`default_nettype none
`include "acio_params.svh"
module acio_top
  import acio_pkg::*;
#(
  // nonvolatile calibration contents, filled per card at build time
  parameter logic [`ACIO_NCH*`ACIO_CODE_W-1:0] P_VOLT_LOW_CAL =
    {`ACIO_NCH{`ACIO_CODE_MIN}},
  parameter logic [`ACIO_NCH*`ACIO_CODE_W-1:0] P_VOLT_HIGH_CAL =
    {`ACIO_NCH{`ACIO_CODE_MAX}},
  parameter logic [`ACIO_NCH*`ACIO_CODE_W-1:0] P_CURR_ZERO_CAL =
    {`ACIO_NCH{`ACIO_CAL_ZERO_DEF}},
  parameter logic [`ACIO_NCH*`ACIO_CODE_W-1:0] P_CURR_FULL_CAL =
    {`ACIO_NCH{`ACIO_CODE_MAX}}
)(
  input  wire logic                              i_clk_sys,
  input  wire logic                              i_nrst,
  input  wire logic [`ACIO_ADDR_W-1:0]           i_io_addr,
  input  wire logic                              i_io_wr,
  input  wire logic                              i_io_rd,
  input  wire logic [`ACIO_IO_W-1:0]             i_io_wdata,
  output logic      [`ACIO_IO_W-1:0]             o_io_rdata,
  input  wire logic [`ACIO_DIO_W-1:0]            i_input_connector,
  output logic      [`ACIO_DIO_W-1:0]            o_output_connector,
  output logic                                   o_di_enable,
  output logic      [`ACIO_NCH*`ACIO_CODE_W-1:0] o_channel_code,
  output logic      [`ACIO_NCH-1:0]              o_channel_load,
  input  wire logic                              i_irq_source_a,
  input  wire logic                              i_irq_source_b,
  output logic                                   o_irq_line_a,
  output logic                                   o_irq_line_b
);

  acio_top_state_t s_q;
  acio_top_state_t s_d;

  logic                     pol_wr;
  logic                     da_wr;
  logic [`ACIO_CODE_W-1:0]  da_code;
  logic [`ACIO_IRQ_N-1:0]   irq_line;
  logic [`ACIO_IRQ_N-1:0]   irq_status;
  logic [`ACIO_CODE_W-1:0]  cal_code;
  logic [`ACIO_IO_W-1:0]    rd_mux;

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  assign pol_wr  = i_io_wr && (i_io_addr == `ACIO_OFS_IRQ_POL);
  // high byte completes the code; low byte only waits in a holding reg
  assign da_wr   = i_io_wr && (i_io_addr == `ACIO_OFS_DA_HI);
  assign da_code = {i_io_wdata[`ACIO_DA_HI_MSB:0], s_q.lo_byte_q};

  // ------------------------------------------------------------
  // calibration store
  // ------------------------------------------------------------
  always_comb begin
    unique case (s_q.cal_kind_q)
      CAL_VOLT_LOW:  cal_code = P_VOLT_LOW_CAL[s_q.cal_ch_q*`ACIO_CODE_W
                                               +: `ACIO_CODE_W];
      CAL_VOLT_HIGH: cal_code = P_VOLT_HIGH_CAL[s_q.cal_ch_q*`ACIO_CODE_W
                                                +: `ACIO_CODE_W];
      CAL_CURR_ZERO: cal_code = P_CURR_ZERO_CAL[s_q.cal_ch_q*`ACIO_CODE_W
                                                +: `ACIO_CODE_W];
      CAL_CURR_FULL: cal_code = P_CURR_FULL_CAL[s_q.cal_ch_q*`ACIO_CODE_W
                                                +: `ACIO_CODE_W];
    endcase
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    case (i_io_addr)
      `ACIO_OFS_IRQ_STATUS: rd_mux = {6'h00, irq_status};
      `ACIO_OFS_DI_LO:      rd_mux = s_q.di_q[7:0];
      `ACIO_OFS_DI_HI:      rd_mux = s_q.di_q[15:8];
      `ACIO_OFS_DO_LO:      rd_mux = s_q.do_q[7:0];
      `ACIO_OFS_DO_HI:      rd_mux = s_q.do_q[15:8];
      `ACIO_OFS_DA_CH:      rd_mux = {4'h0, s_q.ch_q};
      `ACIO_OFS_CAL_SEL:    rd_mux = {2'h0, s_q.cal_kind_q, s_q.cal_ch_q};
      `ACIO_OFS_CAL_LO:     rd_mux = cal_code[7:0];
      `ACIO_OFS_CAL_HI:     rd_mux = {2'h0, cal_code[13:8]};
      default:              rd_mux = '0;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // inputs only sampled once reset has released the port
    s_d.di_en_q = 1'b1;
    if (s_q.di_en_q) begin
      s_d.di_q = i_input_connector;
    end
    if (i_io_rd) begin
      s_d.rdata_q = rd_mux;
    end
    if (i_io_wr) begin
      case (i_io_addr)
        `ACIO_OFS_DO_LO:   s_d.do_q[7:0]  = i_io_wdata;
        `ACIO_OFS_DO_HI:   s_d.do_q[15:8] = i_io_wdata;
        `ACIO_OFS_DA_LO:   s_d.lo_byte_q  = i_io_wdata;
        `ACIO_OFS_DA_CH:   s_d.ch_q       = i_io_wdata[3:0];
        `ACIO_OFS_CAL_SEL: begin
          s_d.cal_ch_q   = i_io_wdata[3:0];
          s_d.cal_kind_q = acio_cal_kind_t'(i_io_wdata[5:4]);
        end
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // reset clears outputs and holds the input port disabled at zero
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q.di_q       <= '0;
      s_q.di_en_q    <= 1'b0;
      s_q.do_q       <= '0;
      s_q.rdata_q    <= '0;
      s_q.lo_byte_q  <= '0;
      s_q.ch_q       <= '0;
      s_q.cal_ch_q   <= '0;
      s_q.cal_kind_q <= CAL_VOLT_LOW;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_io_rdata         = s_q.rdata_q;
  assign o_output_connector = s_q.do_q;
  assign o_di_enable        = s_q.di_en_q;
  assign o_irq_line_a       = irq_line[0];
  assign o_irq_line_b       = irq_line[1];

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  acio_irq u_irq (
    .i_clk_sys    (i_clk_sys),
    .i_nrst       (i_nrst),
    .i_irq_source ({i_irq_source_b, i_irq_source_a}),
    .i_pol_wr     (pol_wr),
    .i_pol_wdata  (i_io_wdata[1:0]),
    .o_irq_line   (irq_line),
    .o_status     (irq_status)
  );

  acio_dac u_dac (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_wr      (da_wr),
    .i_ch      (s_q.ch_q),
    .i_code    (da_code),
    .o_code    (o_channel_code),
    .o_load    (o_channel_load)
  );
endmodule : acio_top
`default_nettype wire

// *** test/acio_host_model.sv ***
// host software model driving the card's i/o registers
`timescale 1ns/1ns
`default_nettype none
module acio_host_model (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_rdata,
  output var  logic [7:0] o_addr = 8'h0,
  output var  logic       o_wr = 1'b0,
  output var  logic       o_rd = 1'b0,
  output var  logic [7:0] o_wdata = 8'h0
);
  // released lines show the inverse, so stale values never pass
  task automatic io(input logic w, input logic [7:0] a,
                    input logic [7:0] d, output logic [7:0] q);
    @(posedge i_clk_sys);
    #1;
    o_addr  = a;
    o_wdata = d;
    o_wr    = w;
    o_rd    = !w;
    @(posedge i_clk_sys);
    #1;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
    q       = i_rdata;
  endtask : io
  function automatic int code_from(int lo, int hi, int n, int d);
    return lo + (hi - lo) * n / d;
  endfunction : code_from
  task automatic isr(inout logic [1:0] saved, inout logic [1:0] inv);
    logic [7:0] s;
    io(1'b0, 8'h07, 8'h0, s);
    inv   = inv ^ (s[1:0] ^ saved);
    saved = s[1:0];
    io(1'b1, 8'h2a, {6'h0, inv}, s);
  endtask : isr
endmodule : acio_host_model
`default_nettype wire

// *** test/acio_top_monitor.sv ***
// port assertions for the analog card digital logic
`timescale 1ns/1ns
`default_nettype none
module acio_top_monitor (
  input wire logic        i_clk_sys,
  input wire logic        i_nrst,
  input wire logic [7:0]  i_io_addr,
  input wire logic        i_io_wr,
  input wire logic        i_io_rd,
  input wire logic [7:0]  i_io_wdata,
  input wire logic [7:0]  o_io_rdata,
  input wire logic [15:0] o_output_connector,
  input wire logic        o_di_enable,
  input wire logic [15:0] o_channel_load,
  input wire logic        i_irq_source_a,
  input wire logic        i_irq_source_b,
  input wire logic        o_irq_line_a,
  input wire logic        o_irq_line_b
);
  logic [1:0] pol_q;
  logic [3:0] ch_q;
  logic       pw;
  assign pw = i_io_wr && (i_io_addr == 8'h2a);
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      pol_q <= 2'h0;
      ch_q  <= 4'h0;
    end else begin
      if (pw) pol_q <= i_io_wdata[1:0];
      if (i_io_wr && (i_io_addr == 8'he2)) ch_q <= i_io_wdata[3:0];
    end
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  chk_reset_clears: assert property (
    !$past(i_nrst) |-> o_output_connector == 16'h0 && o_io_rdata == 8'h0)
    else $error("outputs not clear after reset");
  chk_input_gate: assert property (
    o_di_enable == $past(i_nrst)) else $error("input enable wrong");
  chk_status_read: assert property (
    i_io_rd && i_io_addr == 8'h07 |=>
      o_io_rdata == {6'h0, $past(o_irq_line_b), $past(o_irq_line_a)})
    else $error("status differs from lines");
  // cycle after a polarity write skipped: its latency is a design choice
  chk_line_polar: assert property (
    $past(i_nrst) && !$past(pw) |-> {o_irq_line_b, o_irq_line_a} ==
      ~({$past(i_irq_source_b), $past(i_irq_source_a)} ^ pol_q))
    else $error("irq lines wrong");
  chk_do_low: assert property (
    i_io_wr && i_io_addr == 8'hc2 |=>
      o_output_connector[7:0] == $past(i_io_wdata)) else $error("do low");
  chk_do_high: assert property (
    i_io_wr && i_io_addr == 8'hc3 |=>
      o_output_connector[15:8] == $past(i_io_wdata)) else $error("do high");
  chk_da_commit: assert property (
    i_io_wr && i_io_addr == 8'he1 |->
      ##[1:3] o_channel_load == (16'h1 << ch_q)) else $error("no commit");
  // back-to-back commits are legal, so a fresh commit may follow at once
  chk_load_pulse: assert property (
    o_channel_load != 16'h0 |=> o_channel_load ==
      ($past(i_io_wr && i_io_addr == 8'he1) ? 16'h1 << ch_q : 16'h0))
    else $error("load longer than one cycle");
endmodule : acio_top_monitor
`default_nettype wire

// *** test/analog_card_io_logic_test.sv ***
// self-checking bench for the analog card digital logic
`timescale 1ns/1ns
`default_nettype none
`define CHECK_EQ(g, e) begin checked++; if ((g) !== (e)) begin \
  miscompares++; $display("[ERR] %0t %h %h", $time, g, e); end end
module analog_card_io_logic_test;
  logic         i_clk_sys = 1'b0;
  logic         i_nrst = 1'b0;
  logic [7:0]   i_io_addr, i_io_wdata, o_io_rdata, r;
  logic         i_io_wr, i_io_rd, o_di_enable, o_irq_line_a, o_irq_line_b;
  logic         i_irq_source_a = 1'b0, i_irq_source_b = 1'b0;
  logic [15:0]  i_input_connector = 16'h0, o_output_connector, o_channel_load;
  logic [223:0] code;
  logic [15:0]  cal [4];
  logic [1:0]   saved, inv;
  int           miscompares = 0, checked = 0, x;
  integer       seed = 32'h7950;
  int           code_m [16] = '{default: 0};
  int           cal_def [4] = '{0, 16'h3fff, 16'h2000, 16'h3fff};
  acio_top dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_io_addr(i_io_addr),
    .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
    .o_io_rdata(o_io_rdata), .i_input_connector(i_input_connector),
    .o_output_connector(o_output_connector), .o_di_enable(o_di_enable),
    .o_channel_code(code), .o_channel_load(o_channel_load),
    .i_irq_source_a(i_irq_source_a), .i_irq_source_b(i_irq_source_b),
    .o_irq_line_a(o_irq_line_a), .o_irq_line_b(o_irq_line_b));
  acio_host_model u_host (.i_clk_sys(i_clk_sys), .i_rdata(o_io_rdata),
    .o_addr(i_io_addr), .o_wr(i_io_wr), .o_rd(i_io_rd), .o_wdata(i_io_wdata));
  always #4 i_clk_sys = ~i_clk_sys;
  task automatic print_verdict;
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge i_clk_sys);
    #1;
    `CHECK_EQ(o_di_enable, 1'b0)
    `CHECK_EQ(o_output_connector, 16'h0)
    i_nrst = 1'b1;
    repeat (2) @(posedge i_clk_sys);
    #1;
    `CHECK_EQ(o_di_enable, 1'b1)
    for (int i = 0; i < 4; i++) begin
      i_input_connector = 16'($random(seed));
      x = $random(seed);
      u_host.io(1'b1, 8'hc2, x[7:0], r);
      u_host.io(1'b1, 8'hc3, x[15:8], r);
      `CHECK_EQ(o_output_connector, x[15:0])
      u_host.io(1'b0, 8'hc3, 8'h0, r);
      `CHECK_EQ(r, x[15:8])
      u_host.io(1'b0, 8'hc0, 8'h0, r);
      `CHECK_EQ(r, i_input_connector[7:0])
      u_host.io(1'b0, 8'hc1, 8'h0, r);
      `CHECK_EQ(r, i_input_connector[15:8])
    end
    u_host.io(1'b0, 8'h3f, 8'h0, r);
    `CHECK_EQ(r, 8'h00)
    for (int ch = 0; ch < 16; ch++) begin
      for (int k = 0; k < 4; k++) begin
        u_host.io(1'b1, 8'he4, 8'(k * 16 + ch), r);
        u_host.io(1'b0, 8'he5, 8'h0, cal[k][7:0]);
        u_host.io(1'b0, 8'he6, 8'h0, cal[k][15:8]);
        `CHECK_EQ(cal[k], 16'(cal_def[k]))
      end
      u_host.io(1'b0, 8'he4, 8'h0, r);
      `CHECK_EQ(r, 8'(48 + ch))
      // even channels sit ch/14 of the way up a calibration pair: voltage pair where bit 1 of ch is clear, current pair where set
      x = ch[0] ? $random(seed) & 32'h3fff
                : u_host.code_from(cal[ch & 2], cal[(ch & 2) + 1], ch, 14);
      u_host.io(1'b1, 8'he2, 8'(ch), r);
      u_host.io(1'b0, 8'he2, 8'h0, r);
      `CHECK_EQ(r, 8'(ch))
      u_host.io(1'b1, 8'he0, x[7:0], r);
      repeat (2) @(posedge i_clk_sys);
      #1;
      `CHECK_EQ(code[14*ch +: 14], 14'(code_m[ch]))
      u_host.io(1'b1, 8'he1, {2'h0, x[13:8]}, r);
      code_m[ch] = x;
      repeat (2) @(posedge i_clk_sys);
      #1;
      `CHECK_EQ(code[14*ch +: 14], x[13:0])
    end
    for (int ch = 0; ch < 16; ch++)
      `CHECK_EQ(code[14*ch +: 14], 14'(code_m[ch]))
    for (int p = 0; p < 4; p++) begin
      u_host.io(1'b1, 8'h2a, 8'(p), r);
      for (int s = 0; s < 4; s++) begin
        {i_irq_source_b, i_irq_source_a} = 2'(s);
        u_host.io(1'b0, 8'h07, 8'h0, r);
        `CHECK_EQ(r, 8'(~(s ^ p) & 3))
      end
    end
    saved = 2'h3;
    inv = 2'h3;
    {i_irq_source_b, i_irq_source_a} = 2'h0;
    u_host.isr(saved, inv);
    `CHECK_EQ(saved, 2'h0)
    `CHECK_EQ(inv, 2'h0)
    u_host.io(1'b0, 8'h07, 8'h0, r);
    `CHECK_EQ(r, 8'h03)
    u_host.io(1'b1, 8'hc2, 8'hff, r);
    // reset taken mid-run: outputs must drop at once, not at an edge
    i_nrst = 1'b0;
    #1;
    `CHECK_EQ(o_output_connector, 16'h0)
    `CHECK_EQ(o_di_enable, 1'b0)
    print_verdict();
  end
endmodule : analog_card_io_logic_test
bind acio_top acio_top_monitor u_mon (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
  .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
  .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
  .o_output_connector(o_output_connector), .o_di_enable(o_di_enable),
  .o_channel_load(o_channel_load), .i_irq_source_a(i_irq_source_a),
  .i_irq_source_b(i_irq_source_b), .o_irq_line_a(o_irq_line_a),
  .o_irq_line_b(o_irq_line_b));
`default_nettype wire
